/* File: hw/pwi_pkg.sv */
package pwi_pkg;

   typedef logic [7:0] pwi_byte_t;

   // One-hot register select
   typedef enum logic [5:0] {
      PWI_SEL_NONE = 6'h00,
      PWI_SEL_EV = 6'h01,
      PWI_SEL_EN = 6'h02,
      PWI_SEL_ST = 6'h04,
      PWI_SEL_MK = 6'h08,
      PWI_SEL_GS = 6'h10,
      PWI_SEL_GM = 6'h20
   } pwi_sel_t;

endpackage

/* File: hw/pwi_port.sv */
`timescale 1ns/10ps
`default_nettype none
`include "pwi_regs.svh"

module pwi_port #(
   parameter bit IS_PHY = 1'b1
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register writes
   input wire logic ev_wr,
   input wire logic en_wr,
   input wire logic mask_wr,
   input wire pwi_pkg::pwi_byte_t wdata,
   // Event sources
   input wire logic magic_seen,
   input wire logic [47:0] magic_dst,
   input wire logic [47:0] mac_addr,
   input wire logic link_up_seen,
   input wire logic energy_seen,
   input wire logic phy_irq,
   input wire logic filter_irq,
   // Register contents
   output pwi_pkg::pwi_byte_t ev_reg,
   output pwi_pkg::pwi_byte_t en_reg,
   output pwi_pkg::pwi_byte_t stat_reg,
   output pwi_pkg::pwi_byte_t mask_reg,
   // Requests
   output logic wake_req,
   output logic irq_req
);

   // ****************************************************
   // Event detection
   // ****************************************************
   wire logic magic_hit = magic_seen && (magic_dst == mac_addr);
   wire logic link_hit = IS_PHY && link_up_seen;
   wire logic energy_hit = IS_PHY && energy_seen;
   wire logic [2:0] hit = {magic_hit, link_hit, energy_hit};
   wire logic [2:0] ev_clr = ev_wr ? wdata[2:0] : 3'h0;
   wire logic filter_toggle = mask_wr && (wdata[`PWI_IRQ_FILTER_BIT] != mask_reg[`PWI_IRQ_FILTER_BIT]);

   pwi_pkg::pwi_byte_t ev_next;
   pwi_pkg::pwi_byte_t en_next;
   pwi_pkg::pwi_byte_t stat_next;
   pwi_pkg::pwi_byte_t mask_next;

   // Set wins over write-one clear
   assign ev_next = {5'h00, hit | (ev_reg[2:0] & ~ev_clr)};
   assign en_next = en_wr ? (wdata & `PWI_WAKE_BITS) : en_reg;
   assign mask_next = mask_wr ? (wdata & `PWI_IRQ_BITS) : mask_reg;
   // Filter flag cleared only by toggling its mask bit
   assign stat_next = {6'h00, IS_PHY && phy_irq,
      filter_irq | (stat_reg[`PWI_IRQ_FILTER_BIT] & ~filter_toggle)};

   // ****************************************************
   // Registers
   // ****************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ev_reg <= `PWI_RST_BYTE;
         en_reg <= `PWI_RST_BYTE;
         stat_reg <= `PWI_RST_BYTE;
         mask_reg <= `PWI_RST_BYTE;
      end else begin
         ev_reg <= ev_next;
         en_reg <= en_next;
         stat_reg <= stat_next;
         mask_reg <= mask_next;
      end
   end

   // ****************************************************
   // Requests
   // ****************************************************
   assign wake_req = |(ev_reg[2:0] & en_reg[2:0]);
   assign irq_req = |(stat_reg[1:0] & ~mask_reg[1:0]);

endmodule

`default_nettype wire

/* File: hw/pwi_regs.svh */
`ifndef PWI_REGS_SVH
`define PWI_REGS_SVH

// ****************************************************
// Register indexes (byte address is four times these)
// ****************************************************
`define PWI_IDX_WAKE_EV 12'h013
`define PWI_IDX_WAKE_EN 12'h017
`define PWI_IDX_IRQ_STAT 12'h01B
`define PWI_IDX_IRQ_MASK 12'h01F
`define PWI_IDX_GIRQ_STAT 12'h000
`define PWI_IDX_GIRQ_MASK 12'h001

// ****************************************************
// Byte address fields
// ****************************************************
`define PWI_ADDR_W 17
`define PWI_ADDR_PORT_HI 16
`define PWI_ADDR_PORT_LO 14
`define PWI_ADDR_IDX_HI 13
`define PWI_ADDR_IDX_LO 2
`define PWI_PORT_GLOBAL 3'h0
`define PWI_PORT_FIRST 1
`define PWI_PORT_LAST 7

// ****************************************************
// Field positions
// ****************************************************
`define PWI_WAKE_MAGIC_BIT 2
`define PWI_WAKE_LINK_BIT 1
`define PWI_WAKE_ENERGY_BIT 0
`define PWI_IRQ_PHY_BIT 1
`define PWI_IRQ_FILTER_BIT 0
`define PWI_GIRQ_PIN_BIT 7
`define PWI_WAKE_BITS 8'h07
`define PWI_IRQ_BITS 8'h03

// ****************************************************
// Reset values, bus answers and default PHY port set
// ****************************************************
`define PWI_RST_BYTE 8'h00
`define PWI_RST_WORD 32'h0000_0000
`define PWI_RESP_OKAY 2'h0
`define PWI_RESP_SLVERR 2'h2
`define PWI_PHY_PORTS 7'h1F

`endif

/* File: hw/pwi_top.sv */
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "pwi_regs.svh"

module pwi_top #(
   parameter logic [6:0] PHY_PORTS = `PWI_PHY_PORTS
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [`PWI_ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   // AXI4-Lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // AXI4-Lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [`PWI_ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   // AXI4-Lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // Switch MAC address
   input wire logic [47:0] mac_addr,
   // Per-port event sources, ports 7 to 1
   input wire logic [7:1] magic_seen,
   input wire logic [7:1][47:0] magic_dst,
   input wire logic [7:1] link_up_seen,
   input wire logic [7:1] energy_seen,
   input wire logic [7:1] phy_irq,
   input wire logic [7:1] filter_irq,
   // Outputs
   output logic power_event_pin,
   output logic [7:1] port_irq_req,
   output logic irq
);

   // ****************************************************
   // Write channel capture
   // ****************************************************
   logic aw_got_reg;
   logic w_got_reg;
   logic [`PWI_ADDR_W-1:0] aw_addr_reg;
   logic [7:0] w_data_reg;
   logic w_strb_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;

   wire logic aw_take = awvalid && awready;
   wire logic w_take = wvalid && wready;
   wire logic do_write = aw_got_reg && w_got_reg && !bvalid_reg;
   wire logic ar_take = arvalid && arready;

   assign awready = !aw_got_reg && !bvalid_reg;
   assign wready = !w_got_reg && !bvalid_reg;
   assign arready = !rvalid_reg;
   assign bvalid = bvalid_reg;
   assign bresp = bresp_reg;
   assign rvalid = rvalid_reg;
   assign rdata = rdata_reg;
   assign rresp = rresp_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_reg <= 1'b0;
         aw_addr_reg <= '0;
      end else if (aw_take) begin
         aw_got_reg <= 1'b1;
         aw_addr_reg <= awaddr;
      end else if (do_write) begin
         aw_got_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_got_reg <= 1'b0;
         w_data_reg <= `PWI_RST_BYTE;
         w_strb_reg <= 1'b0;
      end else if (w_take) begin
         w_got_reg <= 1'b1;
         w_data_reg <= wdata[7:0];
         w_strb_reg <= wstrb[0];
      end else if (do_write) begin
         w_got_reg <= 1'b0;
      end
   end

   // ****************************************************
   // Address decode
   // ****************************************************
   function automatic pwi_pkg::pwi_sel_t pwi_decode(input logic [`PWI_ADDR_W-1:0] a);
      logic [2:0] port;
      logic [11:0] idx;
      port = a[`PWI_ADDR_PORT_HI:`PWI_ADDR_PORT_LO];
      idx = a[`PWI_ADDR_IDX_HI:`PWI_ADDR_IDX_LO];
      pwi_decode = pwi_pkg::PWI_SEL_NONE;
      if (a[1:0] == 2'h0) begin
         if (port == `PWI_PORT_GLOBAL) begin
            if (idx == `PWI_IDX_GIRQ_STAT) begin
               pwi_decode = pwi_pkg::PWI_SEL_GS;
            end else if (idx == `PWI_IDX_GIRQ_MASK) begin
               pwi_decode = pwi_pkg::PWI_SEL_GM;
            end
         end else if (idx == `PWI_IDX_WAKE_EV) begin
            pwi_decode = pwi_pkg::PWI_SEL_EV;
         end else if (idx == `PWI_IDX_WAKE_EN) begin
            pwi_decode = pwi_pkg::PWI_SEL_EN;
         end else if (idx == `PWI_IDX_IRQ_STAT) begin
            pwi_decode = pwi_pkg::PWI_SEL_ST;
         end else if (idx == `PWI_IDX_IRQ_MASK) begin
            pwi_decode = pwi_pkg::PWI_SEL_MK;
         end
      end
   endfunction

   wire pwi_pkg::pwi_sel_t wsel = pwi_decode(aw_addr_reg);
   wire pwi_pkg::pwi_sel_t rsel = pwi_decode(araddr);
   wire logic [2:0] wport = aw_addr_reg[`PWI_ADDR_PORT_HI:`PWI_ADDR_PORT_LO];
   wire logic [2:0] rport = araddr[`PWI_ADDR_PORT_HI:`PWI_ADDR_PORT_LO];
   wire logic wr_en = do_write && w_strb_reg;
   wire logic wr_ok = (wsel != pwi_pkg::PWI_SEL_NONE);

   // ****************************************************
   // Ports
   // ****************************************************
   pwi_pkg::pwi_byte_t ev_q [1:7];
   pwi_pkg::pwi_byte_t en_q [1:7];
   pwi_pkg::pwi_byte_t st_q [1:7];
   pwi_pkg::pwi_byte_t mk_q [1:7];
   logic [7:1] wake_req;

   genvar p;
   generate
      for (p = `PWI_PORT_FIRST; p <= `PWI_PORT_LAST; p++) begin : g_port
         wire logic here = wr_en && (wport == 3'(p));
         pwi_port #(
            .IS_PHY(PHY_PORTS[p-1])
         ) u_port (
            .aclk(aclk),
            .aresetn(aresetn),
            .ev_wr(here && (wsel == pwi_pkg::PWI_SEL_EV)),
            .en_wr(here && (wsel == pwi_pkg::PWI_SEL_EN)),
            .mask_wr(here && (wsel == pwi_pkg::PWI_SEL_MK)),
            .wdata(w_data_reg),
            .magic_seen(magic_seen[p]),
            .magic_dst(magic_dst[p]),
            .mac_addr(mac_addr),
            .link_up_seen(link_up_seen[p]),
            .energy_seen(energy_seen[p]),
            .phy_irq(phy_irq[p]),
            .filter_irq(filter_irq[p]),
            .ev_reg(ev_q[p]),
            .en_reg(en_q[p]),
            .stat_reg(st_q[p]),
            .mask_reg(mk_q[p]),
            .wake_req(wake_req[p]),
            .irq_req(port_irq_req[p])
         );
      end
   endgenerate

   // ****************************************************
   // Power event pin and interrupt summary
   // ****************************************************
   logic pin_reg;
   logic [7:1] port_irq_prev_reg;
   logic pin_prev_reg;
   pwi_pkg::pwi_byte_t girq_stat_reg;
   pwi_pkg::pwi_byte_t girq_mask_reg;

   wire pwi_pkg::pwi_byte_t girq_set = {pin_reg & ~pin_prev_reg, port_irq_req & ~port_irq_prev_reg};
   wire logic gs_wr = wr_en && (wsel == pwi_pkg::PWI_SEL_GS);
   wire logic gm_wr = wr_en && (wsel == pwi_pkg::PWI_SEL_GM);
   wire pwi_pkg::pwi_byte_t girq_clr = gs_wr ? w_data_reg : `PWI_RST_BYTE;
   wire pwi_pkg::pwi_byte_t girq_stat_next = girq_set | (girq_stat_reg & ~girq_clr);
   wire pwi_pkg::pwi_byte_t girq_mask_next = gm_wr ? w_data_reg : girq_mask_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_reg <= 1'b0;
      end else begin
         pin_reg <= |wake_req;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_prev_reg <= 1'b0;
         port_irq_prev_reg <= 7'h00;
      end else begin
         pin_prev_reg <= pin_reg;
         port_irq_prev_reg <= port_irq_req;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         girq_stat_reg <= `PWI_RST_BYTE;
      end else begin
         girq_stat_reg <= girq_stat_next;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         girq_mask_reg <= `PWI_RST_BYTE;
      end else begin
         girq_mask_reg <= girq_mask_next;
      end
   end

   assign power_event_pin = pin_reg;
   assign irq = |(girq_stat_reg & girq_mask_reg);

   // ****************************************************
   // Read mux
   // ****************************************************
   wire logic rport_ok = (rport != `PWI_PORT_GLOBAL);
   wire logic [2:0] ridx = rport_ok ? rport : 3'h1;
   pwi_pkg::pwi_byte_t rbyte;

   always_comb begin
      unique case (rsel)
         pwi_pkg::PWI_SEL_EV: rbyte = ev_q[ridx];
         pwi_pkg::PWI_SEL_EN: rbyte = en_q[ridx];
         pwi_pkg::PWI_SEL_ST: rbyte = st_q[ridx];
         pwi_pkg::PWI_SEL_MK: rbyte = mk_q[ridx];
         pwi_pkg::PWI_SEL_GS: rbyte = girq_stat_reg;
         pwi_pkg::PWI_SEL_GM: rbyte = girq_mask_reg;
         default: rbyte = `PWI_RST_BYTE;
      endcase
   end

   // ****************************************************
   // Response codes
   // ****************************************************
   wire logic rd_ok = (rsel != pwi_pkg::PWI_SEL_NONE);
   wire logic [1:0] wr_resp = wr_ok ? `PWI_RESP_OKAY : `PWI_RESP_SLVERR;
   wire logic [1:0] rd_resp = rd_ok ? `PWI_RESP_OKAY : `PWI_RESP_SLVERR;
   wire logic [31:0] rd_word = {24'h000000, rbyte};

   // ****************************************************
   // Responses
   // ****************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= `PWI_RESP_OKAY;
      end else if (do_write) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= wr_resp;
      end else if (bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= `PWI_RST_WORD;
         rresp_reg <= `PWI_RESP_OKAY;
      end else if (ar_take) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= rd_word;
         rresp_reg <= rd_resp;
      end else if (rready) begin
         rvalid_reg <= 1'b0;
      end
   end

endmodule

`default_nettype wire

/* File: sim/pwi_pmc.sv */
`timescale 1ns/10ps
`default_nettype none

module pwi_pmc (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Wake pin
   input wire logic power_event_pin,
   // Wake requests seen
   output var int wake_cnt
);
   logic pin_last;

   // Counts each wake request, one per rising pin level
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wake_cnt <= 0;
         pin_last <= 1'b0;
      end else begin
         pin_last <= power_event_pin;
         if (power_event_pin && !pin_last) begin
            wake_cnt <= wake_cnt + 1;
         end
      end
   end
endmodule

`default_nettype wire

/* File: sim/pwi_top_assertions.sv */
`timescale 1ns/10ps
`default_nettype none

module pwi_top_chk (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus handshakes
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   // Events and outputs
   input wire logic [7:1] magic_seen,
   input wire logic [7:1] link_up_seen,
   input wire logic [7:1] energy_seen,
   input wire logic [7:1] phy_irq,
   input wire logic [7:1] filter_irq,
   input wire logic power_event_pin,
   input wire logic [7:1] port_irq_req,
   input wire logic irq
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_wr_answer; awvalid && awready && wvalid && wready |=> !awready && !wready ##1 bvalid; endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
   property p_b_stands; bvalid && !bready |=> bvalid; endproperty
   a_b_stands: assert property (p_b_stands) else $error("write answer dropped");
   property p_w_refused; bvalid |-> !awready && !wready; endproperty
   a_w_refused: assert property (p_w_refused) else $error("write taken while answering");
   property p_rd_answer; arvalid && arready |=> rvalid && !arready; endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
   property p_r_stands; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
   a_r_stands: assert property (p_r_stands) else $error("read answer changed");
   property p_rd_upper; rvalid |-> rdata[31:8] == 24'h0; endproperty
   a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
   property p_pin_cause;
      $rose(power_event_pin) |-> $past(|{magic_seen, link_up_seen, energy_seen}, 2) || $past(bvalid);
   endproperty
   a_pin_cause: assert property (p_pin_cause) else $error("pin rose without cause");
   property p_pin_drop; $fell(power_event_pin) |-> $past(bvalid); endproperty
   a_pin_drop: assert property (p_pin_drop) else $error("pin fell without write");
   property p_req_rise; $rose(port_irq_req[7]) |-> $past(filter_irq[7]) || bvalid; endproperty
   a_req_rise: assert property (p_req_rise) else $error("request rose without cause");
   property p_req_fall; $fell(port_irq_req[7]) |-> bvalid; endproperty
   a_req_fall: assert property (p_req_fall) else $error("request fell without cause");
   property p_phy_fall; $fell(port_irq_req[3]) |-> !$past(phy_irq[3]) || bvalid; endproperty
   a_phy_fall: assert property (p_phy_fall) else $error("phy request fell without cause");

   c_pin: cover property ($rose(power_event_pin));
   c_irq: cover property ($rose(irq));
   c_read: cover property (rvalid && rready && rdata != 32'h0);
endmodule

bind pwi_top pwi_top_chk chk (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready,
   .arvalid, .arready, .rvalid, .rready, .rdata, .magic_seen, .link_up_seen, .energy_seen, .phy_irq,
   .filter_irq, .power_event_pin, .port_irq_req, .irq);

`default_nettype wire

/* File: sim/tb_pwi_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "pwi_regs.svh"

module tb_pwi_top;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, power_event_pin, irq;
   logic [16:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rnd;
   logic [1:0] bresp, rresp;
   logic [47:0] mac_addr;
   logic [7:1] magic_seen, link_up_seen, energy_seen, phy_irq, filter_irq, port_irq_req;
   logic [7:1][47:0] magic_dst;
   logic [11:0] idx[4] = '{`PWI_IDX_WAKE_EV, `PWI_IDX_WAKE_EN, `PWI_IDX_IRQ_STAT, `PWI_IDX_IRQ_MASK};
   int error_cnt, total_checks, wake_cnt;
   logic [1:0] qb[$];
   logic [33:0] qr[$];

   pwi_top uut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata,
      .wstrb(4'hF), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready,
      .rdata, .rresp, .mac_addr, .magic_seen, .magic_dst, .link_up_seen, .energy_seen, .phy_irq, .filter_irq,
      .power_event_pin, .port_irq_req, .irq);
   pwi_pmc pmc (.aclk, .aresetn, .power_event_pin, .wake_cnt);

   // ****************************************************
   // Helpers
   // ****************************************************
   function automatic logic [31:0] lfsr(logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic [16:0] ad(int p, logic [11:0] i);
      return {3'(p), i, 2'b00};
   endfunction
   task automatic chk(string n, logic [33:0] s, logic [33:0] e);
      total_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(int p, logic [11:0] i, logic [7:0] d, logic [1:0] er);
      @(posedge aclk);
      qb.push_back(er);
      awaddr <= ad(p, i);
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
   endtask
   task automatic rd(int p, logic [11:0] i, logic [7:0] d, logic [1:0] er);
      @(posedge aclk);
      qr.push_back({er, 24'h0, d});
      araddr <= ad(p, i);
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
   endtask
   task automatic pulse(int p, int k);
      @(posedge aclk);
      case (k)
         0: energy_seen[p] <= 1'b1;
         1: link_up_seen[p] <= 1'b1;
         2: magic_seen[p] <= 1'b1;
         default: filter_irq[p] <= 1'b1;
      endcase
      @(posedge aclk);
      {magic_seen, link_up_seen, energy_seen, filter_irq} <= '0;
   endtask
   task automatic tick(int n);
      repeat (n) @(negedge aclk);
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // Compares each bus answer with the oldest note
   always @(posedge aclk) begin
      if (bvalid && bready) chk("bresp", {32'h0, bresp}, {32'h0, qb.pop_front()});
      if (rvalid && rready) chk("read", {rresp, rdata}, qr.pop_front());
   end

   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   initial begin
      #200000;
      error_cnt++;
      close_out();
   end

   // ****************************************************
   // Main sequence
   // ****************************************************
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, phy_irq} = '0;
      {magic_seen, link_up_seen, energy_seen, filter_irq, magic_dst} = '0;
      rnd = lfsr(32'hE89F);
      mac_addr = {rnd[15:0], lfsr(rnd)};
      magic_dst[2] = mac_addr;
      magic_dst[5] = mac_addr ^ 48'h1;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      for (int p = 1; p < 8; p++)
         for (int j = 0; j < 4; j++) rd(p, idx[j], 8'h00, `PWI_RESP_OKAY);
      rd(1, 12'h014, 8'h00, `PWI_RESP_SLVERR);
      wr(1, 12'h014, 8'hFF, `PWI_RESP_SLVERR);
      wr(1, `PWI_IDX_WAKE_EN, 8'h01, `PWI_RESP_OKAY);
      pulse(1, 0);
      tick(3);
      chk("pin", power_event_pin, 1'b1);
      wr(1, `PWI_IDX_WAKE_EV, 8'h01, `PWI_RESP_OKAY);
      for (int k = 0; k < 3; k++) begin
         pulse(2, k);
         tick(3);
         chk("pin", power_event_pin, 1'b0);
         rd(2, `PWI_IDX_WAKE_EV, 8'h01 << k, `PWI_RESP_OKAY);
         wr(2, `PWI_IDX_WAKE_EN, 8'h01 << k, `PWI_RESP_OKAY);
         tick(2);
         chk("pin", power_event_pin, 1'b1);
         wr(2, `PWI_IDX_WAKE_EV, 8'h01 << k, `PWI_RESP_OKAY);
         tick(2);
         chk("pin", power_event_pin, 1'b0);
         wr(2, `PWI_IDX_WAKE_EN, 8'h00, `PWI_RESP_OKAY);
      end
      pulse(5, 2);
      pulse(6, 0);
      pulse(6, 1);
      rd(5, `PWI_IDX_WAKE_EV, 8'h00, `PWI_RESP_OKAY);
      rd(6, `PWI_IDX_WAKE_EV, 8'h00, `PWI_RESP_OKAY);
      @(posedge aclk);
      phy_irq <= 7'h24;
      pulse(7, 3);
      tick(2);
      chk("req", port_irq_req, 7'h44);
      wr(3, `PWI_IDX_IRQ_STAT, 8'hFF, `PWI_RESP_OKAY);
      rd(3, `PWI_IDX_IRQ_STAT, 8'h02, `PWI_RESP_OKAY);
      wr(3, `PWI_IDX_IRQ_MASK, 8'h02, `PWI_RESP_OKAY);
      tick(1);
      chk("req", port_irq_req, 7'h40);
      rd(3, `PWI_IDX_IRQ_MASK, 8'h02, `PWI_RESP_OKAY);
      wr(7, `PWI_IDX_IRQ_STAT, 8'hFF, `PWI_RESP_OKAY);
      rd(7, `PWI_IDX_IRQ_STAT, 8'h01, `PWI_RESP_OKAY);
      wr(7, `PWI_IDX_IRQ_MASK, 8'h01, `PWI_RESP_OKAY);
      rd(7, `PWI_IDX_IRQ_STAT, 8'h00, `PWI_RESP_OKAY);
      wr(0, `PWI_IDX_GIRQ_MASK, 8'hFF, `PWI_RESP_OKAY);
      tick(1);
      chk("irq", irq, 1'b1);
      wr(0, `PWI_IDX_GIRQ_STAT, 8'hFF, `PWI_RESP_OKAY);
      wr(7, `PWI_IDX_IRQ_MASK, 8'h00, `PWI_RESP_OKAY);
      tick(1);
      chk("irq", irq, 1'b0);
      pulse(7, 3);
      tick(2);
      chk("irq", irq, 1'b1);
      wr(0, `PWI_IDX_GIRQ_MASK, 8'h00, `PWI_RESP_OKAY);
      tick(1);
      chk("irq", irq, 1'b0);
      chk("wakes", wake_cnt, 4);
      close_out();
   end
endmodule

`default_nettype wire
